// File: bench/host_control_transfer_sequencer_monitor.sv
// Port-level assertions for the control-transfer sequencer
`timescale 1ns/1ps
`include "ctl_seq_defs.vh"
module host_control_transfer_sequencer_monitor #(
    parameter MAX_PKT_SIZE = 16'd64
) (
    // Clock, reset and register port
    input wire        i_core_clk,
    input wire        i_rst_b,
    input wire [8:0]  i_addr,
    input wire [7:0]  i_wdata,
    input wire        i_wr,
    input wire        i_rd,
    input wire [7:0]  o_rdata,
    // Transaction side
    input wire        o_txn_req,
    input wire [1:0]  o_txn_pid,
    input wire [3:0]  o_txn_hub_addr,
    input wire [2:0]  o_txn_hub_port,
    input wire [3:0]  o_txn_func_addr,
    input wire [3:0]  o_txn_endpoint,
    input wire [15:0] o_txn_len,
    input wire        o_txn_toggle,
    input wire        o_txn_setup_data,
    input wire        i_txn_done,
    input wire [2:0]  i_txn_result
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    wire ctl_wr = i_wr && i_addr == `ADDR_SEQ_CONTROL;
    // ----------------------------------------
    // Launch of a sequence
    // ----------------------------------------
    sequence launch;
        !o_txn_req && ctl_wr && i_wdata[`START_BIT];
    endsequence
    // Token type lags the request by a cycle
    sequence setup_issue;
        o_txn_req && o_txn_len == `SETUP_PACKET_LEN && o_txn_setup_data && !o_txn_toggle
        ##1 o_txn_pid == `TOKEN_SETUP;
    endsequence
    seq_start_a: assert property (launch |=> setup_issue)
        else $error("no setup after start");
    hub_route_a: assert property (i_wr && i_addr == `ADDR_HUB_ROUTING |-> ##2
        o_txn_hub_addr == $past(i_wdata[7:4], 2) && o_txn_hub_port == $past(i_wdata[2:0], 2))
        else $error("hub route not in tokens");
    target_addr_a: assert property (i_wr && i_addr == `ADDR_TARGET_FUNC_EP |-> ##2
        o_txn_func_addr == $past(i_wdata[7:4], 2) && o_txn_endpoint == $past(i_wdata[3:0], 2))
        else $error("target not in tokens");
    stage_read_a: assert property (i_rd && i_addr == `ADDR_SEQ_CONTROL |=>
        o_rdata[7:6] == 2'h0 && o_rdata[3:1] == 3'h0)
        else $error("stray control bits");
    result_read_a: assert property (i_rd && i_addr == `ADDR_RESULT_CODE |=>
        !o_rdata[7] && o_rdata[3:0] == 4'h0)
        else $error("stray result bits");
    manual_token_a: assert property (o_txn_req && $past(o_txn_req) && o_txn_setup_data
        |-> o_txn_pid == `TOKEN_SETUP)
        else $error("manual token leaked");
    status_zlp_a: assert property (o_txn_req && o_txn_len == 16'h0000 |->
        o_txn_toggle && !o_txn_setup_data)
        else $error("bad status packet");
    data_len_a: assert property (o_txn_req && !o_txn_setup_data |-> o_txn_len <= MAX_PKT_SIZE)
        else $error("data packet too long");
    error_stop_a: assert property (o_txn_req && i_txn_done &&
        i_txn_result inside {`RESULT_STALL, `RESULT_OVERRUN, `RESULT_RETRY} |=> !o_txn_req)
        else $error("error did not stop");
    abort_stop_a: assert property (o_txn_req && ctl_wr && !i_wdata[`START_BIT] |=> !o_txn_req)
        else $error("abort ignored");
endmodule // host_control_transfer_sequencer_monitor

bind host_control_transfer_sequencer host_control_transfer_sequencer_monitor #(
    .MAX_PKT_SIZE(MAX_PKT_SIZE)) monitor_inst (
    .i_core_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_txn_req, .o_txn_pid,
    .o_txn_hub_addr, .o_txn_hub_port, .o_txn_func_addr, .o_txn_endpoint, .o_txn_len, .o_txn_toggle,
    .o_txn_setup_data, .i_txn_done, .i_txn_result);

// File: bench/host_control_transfer_sequencer_tb.sv
// Self-checking bench for the control-transfer sequencer
`timescale 1ns/1ps
`include "ctl_seq_defs.vh"
`define CHECK(nm, exp, got) begin \
    tests_run = tests_run + 1; \
    if ((got) !== (exp)) begin \
        failures = failures + 1; \
        $display("Error %0s: expected %0h, seen %0h", nm, exp, got); \
    end \
end
module host_control_transfer_sequencer_tb;
    localparam [44:0] ZERO_AT = {9'h1FF, `ADDR_SEQ_CONTROL, `ADDR_RESULT_CODE, `ADDR_TARGET_FUNC_EP,
                                 `ADDR_HUB_ROUTING};
    localparam [15:0] ERR_AT  = 16'h2410;
    localparam [15:0] ERR_STG = 16'h2321;
    reg         core_clk  = 1'b0;
    reg         rst_b     = 1'b0;
    reg  [8:0]  addr      = 9'h000;
    reg  [7:0]  wdata     = 8'h00;
    reg         wr_s      = 1'b0;
    reg         rd_s      = 1'b0;
    reg  [2:0]  sidx      = 3'h0;
    reg  [7:0]  delay     = 8'h02;
    reg  [3:0]  err_at    = 4'hF;
    reg  [2:0]  err_code  = 3'h0;
    wire [7:0]  rdata, sbyte;
    wire [1:0]  pid;
    wire [3:0]  hub, func, ep;
    wire [2:0]  port, result;
    wire [15:0] len, rx, log;
    wire [14:0] route;
    wire        req, tog, sdata, done, irq;
    reg  [7:0]  v;
    integer     failures  = 0;
    integer     tests_run = 0;
    integer     i, n;

    host_control_transfer_sequencer #(.MAX_PKT_SIZE(16'h0008)) host_control_transfer_sequencer_inst (
        .i_core_clk(core_clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s),
        .o_rdata(rdata), .o_txn_req(req), .o_txn_pid(pid), .o_txn_hub_addr(hub), .o_txn_hub_port(port),
        .o_txn_func_addr(func), .o_txn_endpoint(ep), .o_txn_len(len), .o_txn_toggle(tog),
        .o_txn_setup_data(sdata), .i_txn_done(done), .i_txn_result(result), .i_txn_rx_bytes(rx),
        .i_setup_idx(sidx), .o_setup_byte(sbyte), .i_manual_token_select(`TOKEN_IN), .o_irq(irq));
    usb_function_model usb_function_model_inst (
        .i_core_clk(core_clk), .i_rst_b(rst_b), .i_req(req), .i_pid(pid), .i_len(len),
        .i_route({hub, port, func, ep}), .i_delay(delay), .i_err_at(err_at), .i_err_code(err_code),
        .o_done(done), .o_result(result), .o_rx_bytes(rx), .o_pid_log(log), .o_route(route));

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    // ----------------------------------------
    // Register port tasks
    // ----------------------------------------
    task wr(input [8:0] a, input [7:0] d);
        begin
            @(posedge core_clk);
            addr  <= a;
            wdata <= d;
            wr_s  <= 1'b1;
            @(posedge core_clk);
            wr_s  <= 1'b0;
        end
    endtask
    task rd(input [8:0] a, output [7:0] d);
        begin
            @(posedge core_clk);
            addr <= a;
            rd_s <= 1'b1;
            @(posedge core_clk);
            rd_s <= 1'b0;
            @(negedge core_clk);
            d = rdata;
        end
    endtask
    task start(input [7:0] cfg, input [7:0] bytes, input [7:0] dly, input [3:0] at, input [2:0] code);
        begin
            wr(`ADDR_IRQ_CLEAR, 8'h03);
            delay    <= dly;
            err_at   <= at;
            err_code <= code;
            wr(`ADDR_DATA_STAGE_CFG, cfg);
            wr(`ADDR_DATA_LEN_LO, bytes);
            wr(`ADDR_SEQ_CONTROL, 8'h01);
            rd(`ADDR_SEQ_CONTROL, v);
            `CHECK("setup stage", 8'h11, v)
        end
    endtask
    // Polls the start bit; a hang counts as a mismatch
    task wait_idle;
        begin
            n = 0;
            v = 8'h01;
            while (v[0] !== 1'b0 && n < 300) begin
                rd(`ADDR_SEQ_CONTROL, v);
                n = n + 1;
            end
            if (n >= 300)
                failures = failures + 1;
        end
    endtask
    task summarize;
        begin
            $display("Checks run %0d, mismatches %0d", tests_run, failures);
            if (failures == 0 && tests_run > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin
        #100000;
        failures = failures + 1;
        summarize;
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        for (i = 0; i < 5; i = i + 1) begin
            rd(ZERO_AT[i*9 +: 9], v);
            `CHECK("reset or unmapped", 8'h00, v)
        end
        wr(`ADDR_HUB_ROUTING, 8'hFF);
        rd(`ADDR_HUB_ROUTING, v);
        `CHECK("hub routing", 8'hF7, v)
        wr(`ADDR_HUB_ROUTING, 8'hD6);
        wr(`ADDR_TARGET_FUNC_EP, 8'hA5);
        rd(`ADDR_TARGET_FUNC_EP, v);
        `CHECK("target", 8'hA5, v)
        for (i = 0; i < 8; i = i + 1)
            wr(`ADDR_SETUP_BASE + i[8:0], 8'h30 + i[7:0]);
        sidx <= 3'h7;
        repeat (2) @(posedge core_clk);
        #1;
        `CHECK("setup byte", 8'h37, sbyte)
        wr(`ADDR_IRQ_ENABLE, 8'h03);
        start(8'h00, 8'h00, 8'h06, 4'hF, 3'h0);
        wait_idle;
        `CHECK("clean stage", 8'h00, v)
        rd(`ADDR_IRQ_STATUS, v);
        `CHECK("complete flag", 8'h01, v)
        `CHECK("irq raised", 1'b1, irq)
        `CHECK("tokens no data", 4'h2, log[3:0])
        `CHECK("routing", {4'hD, 3'h6, 4'hA, 4'h5}, route)
        rd(`ADDR_RESULT_CODE, v);
        `CHECK("result none", 8'h00, v)
        wr(`ADDR_IRQ_ENABLE, 8'h00);
        repeat (2) @(posedge core_clk);
        #1;
        `CHECK("irq masked", 1'b0, irq)
        rd(`ADDR_IRQ_STATUS, v);
        `CHECK("sticky flag", 8'h01, v)
        wr(`ADDR_IRQ_CLEAR, 8'h01);
        rd(`ADDR_IRQ_STATUS, v);
        `CHECK("flag cleared", 8'h00, v)
        start(8'h01, 8'h14, 8'h02, 4'hF, 3'h0);
        wait_idle;
        `CHECK("tokens out data", 10'h056, log[9:0])
        start(8'h03, 8'h10, 8'h03, 4'hF, 3'h0);
        wait_idle;
        `CHECK("tokens in data", 8'h29, log[7:0])
        for (i = 0; i < 4; i = i + 1) begin
            start(8'h01, 8'h14, 8'h02, ERR_AT[i*4 +: 4], i[2:0] + 3'h1);
            wait_idle;
            `CHECK("stage after error", {2'h0, ERR_STG[i*4 +: 2], 4'h0}, v)
            rd(`ADDR_RESULT_CODE, v);
            `CHECK("result code", {1'b0, i[2:0] + 3'h1, 4'h0}, v)
            rd(`ADDR_IRQ_STATUS, v);
            `CHECK("stopped flag", 8'h02, v)
        end
        start(8'h00, 8'h00, 8'h28, 4'hF, 3'h0);
        wr(`ADDR_SEQ_CONTROL, 8'h00);
        rd(`ADDR_SEQ_CONTROL, v);
        `CHECK("stage after abort", 8'h10, v)
        rd(`ADDR_IRQ_STATUS, v);
        `CHECK("abort flag", 8'h02, v)
        summarize;
    end
endmodule // host_control_transfer_sequencer_tb

// File: bench/usb_function_model.sv
// Packet engine and endpoint model answering the sequencer
`timescale 1ns/1ps
module usb_function_model (
    // Clock and reset
    input wire         i_core_clk,
    input wire         i_rst_b,
    // Requests from the sequencer
    input wire         i_req,
    input wire [1:0]   i_pid,
    input wire [15:0]  i_len,
    input wire [14:0]  i_route,
    // Behaviour chosen by the bench
    input wire [7:0]   i_delay,
    input wire [3:0]   i_err_at,
    input wire [2:0]   i_err_code,
    // Answers and observations
    output reg         o_done,
    output wire [2:0]  o_result,
    output wire [15:0] o_rx_bytes,
    output reg [15:0]  o_pid_log,
    output reg [14:0]  o_route
);
    reg [7:0]  wait_q;
    reg [3:0]  txn_q;
    reg [2:0]  res_q;
    reg [15:0] rx_q;
    // Between answers the lines show the inverse, not a stale copy
    assign o_result   = o_done ? res_q : ~res_q;
    assign o_rx_bytes = o_done ? rx_q : ~rx_q;
    // ----------------------------------------
    // Answer timing
    // ----------------------------------------
    // A delay of zero would sample the token type before it settles
    always @(posedge i_core_clk) begin
        o_done <= 1'b0;
        if (!i_rst_b) begin
            {wait_q, txn_q, res_q, rx_q, o_pid_log, o_route} <= {62{1'b0}};
        end else if (!i_req || o_done) begin
            wait_q <= 8'h00;
            if (!i_req)
                txn_q <= 4'h0;
        end else if (wait_q == i_delay) begin
            o_done    <= 1'b1;
            res_q     <= (txn_q == i_err_at) ? i_err_code : 3'h0;
            rx_q      <= i_len;
            txn_q     <= txn_q + 4'h1;
            o_pid_log <= {o_pid_log[13:0], i_pid};
            o_route   <= i_route;
            wait_q    <= 8'h00;
        end else begin
            wait_q <= wait_q + 8'h01;
        end
    end
endmodule // usb_function_model

// File: core/ctl_seq_defs.vh
// Register map, field layout and encodings of the control-transfer sequencer
`ifndef CTL_SEQ_DEFS_VH
`define CTL_SEQ_DEFS_VH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define ADDR_HUB_ROUTING      9'h188
`define ADDR_TARGET_FUNC_EP   9'h189
`define ADDR_SEQ_CONTROL      9'h18B
`define ADDR_RESULT_CODE      9'h18E
`define ADDR_SETUP_BASE       9'h1A0
`define ADDR_DATA_STAGE_CFG   9'h1B0
`define ADDR_DATA_LEN_HI      9'h1B1
`define ADDR_DATA_LEN_LO      9'h1B2
`define ADDR_IRQ_STATUS       9'h1B4
`define ADDR_IRQ_CLEAR        9'h1B5
`define ADDR_IRQ_ENABLE       9'h1B6

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define HUB_ADDR_MSB          7
`define HUB_ADDR_LSB          4
`define HUB_PORT_MSB          2
`define HUB_PORT_LSB          0
`define FUNC_ADDR_MSB         7
`define FUNC_ADDR_LSB         4
`define ENDP_MSB              3
`define ENDP_LSB              0
`define START_BIT             0
`define CFG_HAS_DATA_BIT      0
`define CFG_DIR_IN_BIT        1
`define IRQ_COMPLETE_BIT      0
`define IRQ_STOPPED_BIT       1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_HUB_ROUTING       8'h00
`define RST_TARGET_FUNC_EP    8'h00
`define RST_RESULT_CODE       3'h0

// ----------------------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------------------
`define TOKEN_SETUP           2'h0
`define TOKEN_OUT             2'h1
`define TOKEN_IN              2'h2
`define STAGE_IDLE            2'h0
`define STAGE_SETUP           2'h1
`define STAGE_DATA            2'h2
`define STAGE_STATUS          2'h3
`define RESULT_NO_ERROR       3'h0
`define RESULT_STALL          3'h1
`define RESULT_OVERRUN        3'h2
`define RESULT_UNDERRUN       3'h3
`define RESULT_RETRY          3'h4
`define SETUP_PACKET_LEN      16'h0008

`endif

// File: core/host_control_transfer_sequencer.v
// Control-transfer sequencer for host channel 0 with its register port and interrupt
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "ctl_seq_defs.vh"
module host_control_transfer_sequencer #(
    parameter MAX_PKT_SIZE = 16'd64
) (
    // Clock and reset
    input  wire        i_core_clk,
    input  wire        i_rst_b,
    // Register port
    input  wire [8:0]  i_addr,
    input  wire [7:0]  i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [7:0]  o_rdata,
    // Transaction request to the packet engine
    output reg         o_txn_req,
    output reg  [1:0]  o_txn_pid,
    output reg  [3:0]  o_txn_hub_addr,
    output reg  [2:0]  o_txn_hub_port,
    output reg  [3:0]  o_txn_func_addr,
    output reg  [3:0]  o_txn_endpoint,
    output reg  [15:0] o_txn_len,
    output reg         o_txn_toggle,
    output reg         o_txn_setup_data,
    // Transaction outcome from the packet engine
    input  wire        i_txn_done,
    input  wire [2:0]  i_txn_result,
    input  wire [15:0] i_txn_rx_bytes,
    // Setup payload fetch
    input  wire [2:0]  i_setup_idx,
    output wire [7:0]  o_setup_byte,
    // Manual token selection for non-sequenced transactions
    input  wire [1:0]  i_manual_token_select,
    // Interrupt
    output reg         o_irq
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function [15:0] pkt_len;
        input [15:0] remaining;
        begin
            pkt_len = (remaining > MAX_PKT_SIZE) ? MAX_PKT_SIZE : remaining;
        end
    endfunction

    function is_addr;
        input [8:0] a;
        input [8:0] ref_a;
        begin
            is_addr = (a == ref_a);
        end
    endfunction

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    reg  [7:0]  hub_routing_q;
    reg  [7:0]  target_func_ep_q;
    reg  [2:0]  result_code_q;
    reg  [1:0]  data_cfg_q;
    reg  [15:0] data_len_q;
    reg  [1:0]  irq_status_q;
    reg  [1:0]  irq_enable_q;

    reg         active_q;
    reg  [1:0]  stage_q;
    reg  [1:0]  pid_q;
    reg  [15:0] remain_q;
    reg         cmp_pulse_q;
    reg         stop_pulse_q;

    wire        wr_setup  = i_wr && (i_addr[8:3] == `ADDR_SETUP_BASE >> 3);
    wire        wr_ctl    = i_wr && is_addr(i_addr, `ADDR_SEQ_CONTROL);
    wire        start_wr  = wr_ctl && i_wdata[`START_BIT];
    wire        abort_wr  = wr_ctl && !i_wdata[`START_BIT];
    wire        dir_in    = data_cfg_q[`CFG_DIR_IN_BIT];
    wire        has_data  = data_cfg_q[`CFG_HAS_DATA_BIT] && (data_len_q != 16'h0000);
    wire [7:0]  setup_sw_byte;

    // An underrun in the data stage is not an error; the stage ends on a short IN packet or once the length is used up
    wire        txn_ok    = (i_txn_result == `RESULT_NO_ERROR) ||
                            ((i_txn_result == `RESULT_UNDERRUN) && (stage_q == `STAGE_DATA));
    wire [15:0] sent      = dir_in ? i_txn_rx_bytes : o_txn_len;
    wire [15:0] rem_next  = (sent > remain_q) ? 16'h0000 : remain_q - sent;
    wire        short_pkt = dir_in && (i_txn_rx_bytes < o_txn_len);
    wire [1:0]  stat_pid  = (has_data && dir_in) ? `TOKEN_OUT : `TOKEN_IN;
    wire        done_now  = active_q && o_txn_req && i_txn_done;

    // ------------------------------------------------------------------------
    // Setup request bytes
    // ------------------------------------------------------------------------
    setup_request_store #(
        .DEPTH (8),
        .IDX_W (3)
    ) u_setup_store (
        .i_core_clk (i_core_clk),
        .i_rst_b    (i_rst_b),
        .i_wr_en    (wr_setup),
        .i_wr_idx   (i_addr[2:0]),
        .i_wdata    (i_wdata),
        .i_sw_idx   (i_addr[2:0]),
        .o_sw_byte  (setup_sw_byte),
        .i_tx_idx   (i_setup_idx),
        .o_tx_byte  (o_setup_byte)
    );

    // ------------------------------------------------------------------------
    // Software-written configuration
    // ------------------------------------------------------------------------
    always @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            hub_routing_q    <= `RST_HUB_ROUTING;
            target_func_ep_q <= `RST_TARGET_FUNC_EP;
            data_cfg_q       <= 2'h0;
            data_len_q       <= 16'h0000;
            irq_enable_q     <= 2'h0;
        end else if (i_wr) begin
            if (is_addr(i_addr, `ADDR_HUB_ROUTING)) begin
                // Reserved bit 3 is never stored
                hub_routing_q <= {i_wdata[`HUB_ADDR_MSB:`HUB_ADDR_LSB], 1'b0,
                                  i_wdata[`HUB_PORT_MSB:`HUB_PORT_LSB]};
            end
            if (is_addr(i_addr, `ADDR_TARGET_FUNC_EP)) begin
                target_func_ep_q <= i_wdata;
            end
            if (is_addr(i_addr, `ADDR_DATA_STAGE_CFG)) begin
                data_cfg_q <= i_wdata[1:0];
            end
            if (is_addr(i_addr, `ADDR_DATA_LEN_HI)) begin
                data_len_q[15:8] <= i_wdata;
            end
            if (is_addr(i_addr, `ADDR_DATA_LEN_LO)) begin
                data_len_q[7:0] <= i_wdata;
            end
            if (is_addr(i_addr, `ADDR_IRQ_ENABLE)) begin
                irq_enable_q <= i_wdata[1:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    // The configuration registers are not locked while running; software must
    // not change them mid-transfer.
    always @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            active_q         <= 1'b0;
            stage_q          <= `STAGE_IDLE;
            pid_q            <= `TOKEN_SETUP;
            remain_q         <= 16'h0000;
            o_txn_req        <= 1'b0;
            o_txn_len        <= 16'h0000;
            o_txn_toggle     <= 1'b0;
            o_txn_setup_data <= 1'b0;
            cmp_pulse_q      <= 1'b0;
            stop_pulse_q     <= 1'b0;
        end else begin
            cmp_pulse_q  <= 1'b0;
            stop_pulse_q <= 1'b0;
            if (start_wr && !active_q) begin
                active_q         <= 1'b1;
                stage_q          <= `STAGE_SETUP;
                pid_q            <= `TOKEN_SETUP;
                o_txn_req        <= 1'b1;
                o_txn_len        <= `SETUP_PACKET_LEN;
                o_txn_toggle     <= 1'b0;
                o_txn_setup_data <= 1'b1;
            end else if (abort_wr && active_q) begin
                active_q  <= 1'b0;
                o_txn_req <= 1'b0;
                if (done_now && txn_ok && (stage_q == `STAGE_STATUS)) begin
                    cmp_pulse_q <= 1'b1;
                    stage_q     <= `STAGE_IDLE;
                end else begin
                    stop_pulse_q <= 1'b1;
                end
            end else if (done_now) begin
                if (!txn_ok) begin
                    // Stage is left as it was so software sees where it halted
                    active_q     <= 1'b0;
                    o_txn_req    <= 1'b0;
                    stop_pulse_q <= 1'b1;
                end else begin
                    case (stage_q)
                        `STAGE_SETUP: begin
                            o_txn_setup_data <= 1'b0;
                            o_txn_toggle     <= 1'b1;
                            if (has_data) begin
                                stage_q   <= `STAGE_DATA;
                                pid_q     <= dir_in ? `TOKEN_IN : `TOKEN_OUT;
                                remain_q  <= data_len_q;
                                o_txn_len <= pkt_len(data_len_q);
                            end else begin
                                stage_q   <= `STAGE_STATUS;
                                pid_q     <= stat_pid;
                                o_txn_len <= 16'h0000;
                            end
                        end
                        `STAGE_DATA: begin
                            if ((rem_next == 16'h0000) || short_pkt) begin
                                stage_q      <= `STAGE_STATUS;
                                pid_q        <= stat_pid;
                                o_txn_len    <= 16'h0000;
                                o_txn_toggle <= 1'b1;
                            end else begin
                                remain_q     <= rem_next;
                                o_txn_len    <= pkt_len(rem_next);
                                o_txn_toggle <= ~o_txn_toggle;
                            end
                        end
                        `STAGE_STATUS: begin
                            active_q    <= 1'b0;
                            o_txn_req   <= 1'b0;
                            stage_q     <= `STAGE_IDLE;
                            cmp_pulse_q <= 1'b1;
                        end
                        default: begin
                            active_q  <= 1'b0;
                            o_txn_req <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Token fields
    // ------------------------------------------------------------------------
    always @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_txn_pid       <= `TOKEN_SETUP;
            o_txn_hub_addr  <= 4'h0;
            o_txn_hub_port  <= 3'h0;
            o_txn_func_addr <= 4'h0;
            o_txn_endpoint  <= 4'h0;
        end else begin
            // The sequencer owns the token type while it runs
            o_txn_pid       <= active_q ? pid_q : i_manual_token_select;
            o_txn_hub_addr  <= hub_routing_q[`HUB_ADDR_MSB:`HUB_ADDR_LSB];
            o_txn_hub_port  <= hub_routing_q[`HUB_PORT_MSB:`HUB_PORT_LSB];
            o_txn_func_addr <= target_func_ep_q[`FUNC_ADDR_MSB:`FUNC_ADDR_LSB];
            o_txn_endpoint  <= target_func_ep_q[`ENDP_MSB:`ENDP_LSB];
        end
    end

    // ------------------------------------------------------------------------
    // Result code
    // ------------------------------------------------------------------------
    always @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            result_code_q <= `RST_RESULT_CODE;
        end else if (done_now) begin
            result_code_q <= i_txn_result;
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------------
    reg [1:0] irq_set;
    reg [1:0] irq_clr;
    reg [1:0] irq_status_d;

    always @* begin
        irq_set = 2'h0;
        irq_set[`IRQ_COMPLETE_BIT] = cmp_pulse_q;
        irq_set[`IRQ_STOPPED_BIT]  = stop_pulse_q;
        irq_clr = (i_wr && is_addr(i_addr, `ADDR_IRQ_CLEAR)) ? i_wdata[1:0] : 2'h0;
        // A new event in the clearing cycle survives
        irq_status_d = (irq_status_q & ~irq_clr) | irq_set;
    end

    always @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            irq_status_q <= 2'h0;
            o_irq        <= 1'b0;
        end else begin
            irq_status_q <= irq_status_d;
            o_irq        <= |(irq_status_d & irq_enable_q);
        end
    end

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------
    reg [7:0] rd_mux;

    always @* begin
        rd_mux = 8'h00;
        case (i_addr)
            `ADDR_HUB_ROUTING:    rd_mux = hub_routing_q;
            `ADDR_TARGET_FUNC_EP: rd_mux = target_func_ep_q;
            `ADDR_SEQ_CONTROL:    rd_mux = {2'h0, stage_q, 3'h0, active_q};
            `ADDR_RESULT_CODE:    rd_mux = {1'b0, result_code_q, 4'h0};
            `ADDR_DATA_STAGE_CFG: rd_mux = {6'h00, data_cfg_q};
            `ADDR_DATA_LEN_HI:    rd_mux = data_len_q[15:8];
            `ADDR_DATA_LEN_LO:    rd_mux = data_len_q[7:0];
            `ADDR_IRQ_STATUS:     rd_mux = {6'h00, irq_status_q};
            `ADDR_IRQ_ENABLE:     rd_mux = {6'h00, irq_enable_q};
            default: begin
                if (i_addr[8:3] == `ADDR_SETUP_BASE >> 3) begin
                    rd_mux = setup_sw_byte;
                end
            end
        endcase
    end

    always @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= i_rd ? rd_mux : 8'h00;
        end
    end

endmodule // host_control_transfer_sequencer

// File: core/setup_request_store.v
// Eight-byte store for the setup request, written by software, read by the packet sender
`timescale 1ns/1ps
module setup_request_store #(
    parameter DEPTH = 8,
    parameter IDX_W = 3
) (
    // Clock and reset
    input  wire             i_core_clk,
    input  wire             i_rst_b,
    // Software side
    input  wire             i_wr_en,
    input  wire [IDX_W-1:0] i_wr_idx,
    input  wire [7:0]       i_wdata,
    input  wire [IDX_W-1:0] i_sw_idx,
    output wire [7:0]       o_sw_byte,
    // Packet sender side
    input  wire [IDX_W-1:0] i_tx_idx,
    output reg  [7:0]       o_tx_byte
);

    reg [7:0] mem_q [0:DEPTH-1];
    integer   k;

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    always @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            for (k = 0; k < DEPTH; k = k + 1) begin
                mem_q[k] <= 8'h00;
            end
            o_tx_byte <= 8'h00;
        end else begin
            if (i_wr_en) begin
                mem_q[i_wr_idx] <= i_wdata;
            end
            // Sender gets the byte one cycle after presenting the index
            o_tx_byte <= mem_q[i_tx_idx];
        end
    end

    assign o_sw_byte = mem_q[i_sw_idx];

endmodule // setup_request_store
